// file: dibd_map.svh
// Register offsets, field positions, reset values and timing counts
// for the DAC input bus demultiplexer. Definitions only.
`ifndef DIBD_MAP_SVH
`define DIBD_MAP_SVH

`define DIBD_CTRL_OFFSET 12'h000
`define DIBD_STATUS_OFFSET 12'h004
`define DIBD_SAMPLE_OFFSET 12'h008

`define DIBD_CTRL_INTERLEAVE 0
`define DIBD_CTRL_MARKER 1
`define DIBD_CTRL_DUAL_CLOCK 2
`define DIBD_CTRL_STROBE_SYNC 3
`define DIBD_CTRL_SEL_LO 4
`define DIBD_CTRL_SEL_HI 5
`define DIBD_CTRL_EXT_CLOCK 6
`define DIBD_CTRL_WIDTH 7
`define DIBD_CTRL_RESET 7'h00

`define DIBD_STAGES 4
`define DIBD_WORD_WIDTH 16
`define DIBD_CNT_WIDTH 4

`endif

// file: dibd_pkg.sv
// Types shared by the DAC input bus demultiplexer.
// Used with the constants of dibd_map.svh.
package dibd_pkg;

    typedef enum logic [1:0] {
        DIBD_STEER_A = 2'b01,
        DIBD_STEER_B = 2'b10
    } dibd_steer_t;

    typedef enum logic [1:0] {
        DIBD_INTERP_2X = 2'b00,
        DIBD_INTERP_4X = 2'b01,
        DIBD_INTERP_8X = 2'b10,
        DIBD_INTERP_16X = 2'b11
    } dibd_interp_t;

endpackage : dibd_pkg

// file: dibd_top.sv
// Input-side capture and I/Q demultiplexing for a dual-channel interpolating DAC,
// with filter stage clock enables and the divided input clock.
// Assumes mclk_i is the sample-rate clock and all pins are synchronous to it.
// Behaviour
// (RULE1) Stage n runs at sample clock over 2^n
// (RULE2) Twofold interpolation uses one half-rate stage
// (RULE3) Fourfold uses half and quarter rate stages
// (RULE4) Two-bus mode accepts both buses in parallel
// (RULE5) Interleave bit 0 selects two-bus mode
// (RULE6) Interleaved words arrive on primary bus only
// (RULE7) Interleave bit 1 selects interleaved mode
// (RULE8) Interleaved words alternate into channels A, B
// (RULE9) Marker bit 0: first word after gate is A
// (RULE10) Following words alternate B then A
// (RULE11) Marker bit 1: host drives channel marker
// (RULE12) Marker high routes word to channel B
// (RULE13) Interleaved PLL words at twice first-stage rate
// (RULE14) Interleaved PLL divider is not strobe-synchronised
// (RULE15) Multi-device interleaved alignment should use dual clock
// (RULE16) Dual-clock bit high enables dual-clock operation
// (RULE17) Dual clock: capture on input data clock
// (RULE18) External mode runs directly at sample rate
// (RULE19) Divided clock may take N phases
// (RULE20) Strobe-sync bit makes strobe reset dividers; code resets them only in external mode
// (RULE21) Strobe rising edge restarts divided clock phase
// (RULE22) Two-bus words captured together as one pair
// (RULE23) Steering holds state; gate rise realigns to A
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "dibd_map.svh"

module dibd_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Sample buses and sideband pins
    input wire logic [`DIBD_WORD_WIDTH-1:0] primary_input_bus_i,
    input wire logic [`DIBD_WORD_WIDTH-1:0] secondary_input_bus_i,
    input wire logic transmit_gate_i,
    input wire logic channel_marker_i,
    input wire logic input_data_clock_i,
    input wire logic phase_strobe_i,
    input wire logic pll_lock_i,
    // Demultiplexed sample path
    output logic [`DIBD_WORD_WIDTH-1:0] chan_a_o,
    output logic [`DIBD_WORD_WIDTH-1:0] chan_b_o,
    output logic pair_valid_o,
    output logic [`DIBD_STAGES-1:0] stage_clk_en_o,
    output logic lock_or_divided_clock_o
);

    logic [`DIBD_CTRL_WIDTH-1:0] ctrl;
    logic [`DIBD_CNT_WIDTH-1:0] div_cnt;
    logic [`DIBD_CNT_WIDTH-1:0] word_mask;
    logic [`DIBD_STAGES-1:0] next_stage_en;
    dibd_pkg::dibd_steer_t steer;
    logic gate_q;
    logic strobe_q;
    logic data_clk_q;
    logic word_tick;
    logic capture;
    logic strobe_rise;
    logic gate_rise;
    logic div_clk;
    logic mode_interleave;
    logic mode_marker;
    logic mode_dual;
    logic mode_sync;
    logic mode_ext;
    logic [1:0] interp_sel;
    logic apb_setup;
    logic apb_write;

    assign mode_interleave = ctrl[`DIBD_CTRL_INTERLEAVE];
    assign mode_marker = ctrl[`DIBD_CTRL_MARKER];
    assign mode_dual = ctrl[`DIBD_CTRL_DUAL_CLOCK];
    assign mode_sync = ctrl[`DIBD_CTRL_STROBE_SYNC];
    assign mode_ext = ctrl[`DIBD_CTRL_EXT_CLOCK];
    assign interp_sel = ctrl[`DIBD_CTRL_SEL_HI:`DIBD_CTRL_SEL_LO];

    // APB: pready rises in the access phase, so every transfer is zero-wait
    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pready_o && pwrite_i;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= apb_setup;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (apb_setup) begin
            pslverr_o <= 1'b0;
            unique case (paddr_i)
                `DIBD_CTRL_OFFSET: prdata_o <= {25'h000_0000, ctrl};
                `DIBD_STATUS_OFFSET: prdata_o <= {20'h0_0000, div_cnt, 4'h0, strobe_q, gate_q, steer};
                `DIBD_SAMPLE_OFFSET: prdata_o <= {chan_b_o, chan_a_o};
                default: begin
                    prdata_o <= 32'h0000_0000;
                    pslverr_o <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl <= `DIBD_CTRL_RESET;
        end else if (apb_write && paddr_i == `DIBD_CTRL_OFFSET) begin
            ctrl <= pwdata_i[`DIBD_CTRL_WIDTH-1:0];
        end
    end

    // Edge detection of pins; all taken as synchronous to mclk_i
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gate_q <= 1'b0;
            strobe_q <= 1'b0;
            data_clk_q <= 1'b0;
        end else begin
            gate_q <= transmit_gate_i;
            strobe_q <= phase_strobe_i;
            data_clk_q <= input_data_clock_i;
        end
    end

    assign gate_rise = transmit_gate_i && !gate_q;
    assign strobe_rise = phase_strobe_i && !strobe_q;

    // Divider for stage enables and the divided input clock.
    // In PLL mode the strobe is ignored, so several devices may differ by one word period.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_cnt <= 4'h0;
        end else if (mode_sync && mode_ext && strobe_rise) begin // RULE20 RULE21 RULE14
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1; // RULE18
        end
    end

    // Word period: N in two-bus mode, N/2 when words are interleaved
    always_comb begin
        word_mask = 4'h0;
        unique case (dibd_pkg::dibd_interp_t'(interp_sel))
            dibd_pkg::DIBD_INTERP_2X: word_mask = mode_interleave ? 4'h0 : 4'h1; // RULE13
            dibd_pkg::DIBD_INTERP_4X: word_mask = mode_interleave ? 4'h1 : 4'h3;
            dibd_pkg::DIBD_INTERP_8X: word_mask = mode_interleave ? 4'h3 : 4'h7;
            dibd_pkg::DIBD_INTERP_16X: word_mask = mode_interleave ? 4'h7 : 4'hF;
        endcase
    end

    // Phase depends on where the free-running divider stands
    assign div_clk = (div_cnt & word_mask) <= (word_mask >> 1); // RULE19
    assign word_tick = mode_dual ? (input_data_clock_i && !data_clk_q) // RULE16 RULE17
                                 : ((div_cnt & word_mask) == 4'h0);

    // Interleave gate mode only takes words while the gate is high
    assign capture = word_tick && (!mode_interleave || mode_marker || transmit_gate_i);

    genvar gi;
    generate
        for (gi = 0; gi < `DIBD_STAGES; gi = gi + 1) begin : g_stage
            // Stage gi+1 active when interpolation is 2^(gi+1) or higher
            assign next_stage_en[gi] = (div_cnt[gi:0] == '0) && (interp_sel >= 2'(gi)); // RULE1 RULE2 RULE3
        end
    endgenerate

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stage_clk_en_o <= 4'h0;
            lock_or_divided_clock_o <= 1'b0;
        end else begin
            stage_clk_en_o <= next_stage_en;
            lock_or_divided_clock_o <= mode_ext ? div_clk : pll_lock_i;
        end
    end

    // Channel steering; the state is kept between words
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            steer <= dibd_pkg::DIBD_STEER_A;
        end else if (!mode_interleave || mode_marker) begin
            steer <= dibd_pkg::DIBD_STEER_A;
        end else if (gate_rise && !capture) begin
            steer <= dibd_pkg::DIBD_STEER_A; // RULE23
        end else if (capture) begin
            unique case (steer)
                dibd_pkg::DIBD_STEER_A: steer <= dibd_pkg::DIBD_STEER_B; // RULE10
                dibd_pkg::DIBD_STEER_B: steer <= gate_rise ? dibd_pkg::DIBD_STEER_B
                                                           : dibd_pkg::DIBD_STEER_A;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chan_a_o <= 16'h0000;
            chan_b_o <= 16'h0000;
            pair_valid_o <= 1'b0;
        end else begin
            pair_valid_o <= 1'b0;
            if (capture) begin
                if (!mode_interleave) begin // RULE5
                    chan_a_o <= primary_input_bus_i; // RULE4 RULE22
                    chan_b_o <= secondary_input_bus_i;
                    pair_valid_o <= 1'b1;
                end else if (mode_marker) begin // RULE7
                    if (channel_marker_i) begin // RULE12
                        chan_b_o <= primary_input_bus_i;
                        pair_valid_o <= 1'b1;
                    end else begin
                        chan_a_o <= primary_input_bus_i;
                    end
                end else if (gate_rise || steer == dibd_pkg::DIBD_STEER_A) begin // RULE9 RULE8
                    chan_a_o <= primary_input_bus_i; // RULE6
                end else begin
                    chan_b_o <= primary_input_bus_i;
                    pair_valid_o <= 1'b1;
                end
            end
        end
    end

endmodule : dibd_top

// file: dibd_properties.sv
// Checker on dibd_top ports for the sample path and stage enables.
// Mirrors CTRL from APB writes; modes are held steady by the bench.
`timescale 1ns/1ps
module dibd_properties (
    // Clock, reset and APB
    input wire logic mclk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    // Sample path
    input wire logic [15:0] primary_input_bus_i, secondary_input_bus_i, chan_a_o, chan_b_o,
    input wire logic transmit_gate_i, channel_marker_i, input_data_clock_i, pair_valid_o, phase_strobe_i,
    input wire logic [3:0] stage_clk_en_o
);
    logic [6:0] ctrl;
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) ctrl <= 7'h00;
        else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == 12'h000) ctrl <= pwdata_i[6:0];
    end
    // A strobe restart legally breaks the stage cadence once; the stage 0 and stage 1 rate checks pause then
    logic strobe_d;
    logic [3:0] quiet;
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            strobe_d <= 1'b0;
            quiet <= 4'hF;
        end else begin
            strobe_d <= phase_strobe_i;
            if (ctrl[3] && ctrl[6] && phase_strobe_i && !strobe_d) quiet <= 4'h0;
            else if (quiet != 4'hF) quiet <= quiet + 4'h1;
        end
    end
    wire two = !ctrl[0];
    wire ilv = ctrl[5:0] == 6'h01;
    wire mrk = ctrl[5:0] == 6'h03;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    property p_half; disable iff (sys_rst_i || quiet != 4'hF) stage_clk_en_o[0] |=> !stage_clk_en_o[0]; endproperty
    a_half: assert property (p_half) else $error("stage 0 not half rate");
    property p_sel2; ctrl[5:4] == 2'h0 |=> stage_clk_en_o[3:1] == 3'h0; endproperty
    a_sel2: assert property (p_sel2) else $error("extra stage at 2x");
    property p_sel4; disable iff (sys_rst_i || quiet != 4'hF)
        ctrl[5:4] == 2'h1 && stage_clk_en_o[1] |=> !stage_clk_en_o[1] [*3]; endproperty
    a_sel4: assert property (p_sel4) else $error("stage 1 not quarter rate");
    property p_pair; two |=> (pair_valid_o |-> chan_a_o == $past(primary_input_bus_i)
        && chan_b_o == $past(secondary_input_bus_i)); endproperty
    a_pair: assert property (p_pair) else $error("two-bus pair wrong");
    property p_gate; ilv && $rose(transmit_gate_i) |=> (chan_a_o == $past(primary_input_bus_i) && !pair_valid_o)
        ##1 (!$past(transmit_gate_i) || pair_valid_o && chan_b_o == $past(primary_input_bus_i)); endproperty
    a_gate: assert property (p_gate) else $error("gate order wrong");
    property p_idle; ilv && !transmit_gate_i |=> !pair_valid_o && $stable(chan_a_o); endproperty
    a_idle: assert property (p_idle) else $error("word taken with gate low");
    property p_mrk; mrk |=> (pair_valid_o |-> $past(channel_marker_i) && chan_b_o == $past(primary_input_bus_i));
    endproperty
    a_mrk: assert property (p_mrk) else $error("marker routing wrong");
    property p_dual; ctrl[2] |=> (pair_valid_o |-> $past(input_data_clock_i) && !$past(input_data_clock_i, 2));
    endproperty
    a_dual: assert property (p_dual) else $error("capture off data clock");
    c_ilv: cover property (ilv && pair_valid_o);
    c_mrk: cover property (mrk && pair_valid_o);
    c_dual: cover property (ctrl[2] && pair_valid_o);
endmodule : dibd_properties

bind dibd_top dibd_properties dibd_properties_i (.mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .pready_o,
    .paddr_i, .pwdata_i, .primary_input_bus_i, .secondary_input_bus_i, .chan_a_o, .chan_b_o, .transmit_gate_i,
    .channel_marker_i, .input_data_clock_i, .pair_valid_o, .phase_strobe_i, .stage_clk_en_o);

// file: dibd_host_model.sv
// Host side: sample buses, gate, marker and input data clock.
// Words change every cycle, so stale data never looks valid.
`timescale 1ns/1ps
module dibd_host_model (
    input wire logic mclk_i, run_i, dual_i,
    output logic [15:0] primary_o, secondary_o,
    output logic gate_o, marker_o, idclk_o
);
    logic [7:0] cnt;
    initial {cnt, primary_o, secondary_o, gate_o, marker_o, idclk_o} = 43'h0;
    always @(posedge mclk_i) begin
        cnt <= cnt + 8'h01;
        primary_o <= {8'hA5, cnt};
        secondary_o <= {8'h5A, ~cnt};
        gate_o <= run_i;
        marker_o <= run_i && !marker_o;
        idclk_o <= dual_i && run_i && cnt[1];
    end
endmodule : dibd_host_model

// file: dac_input_bus_demux_test.sv
// Bench for dibd_top: APB access, then bursts in each input mode.
// Host model drives sample pins; lock is tied high and the bench drives the strobe.
`timescale 1ns/1ps
module dac_input_bus_demux_test;
    logic mclk_i = 1'h0, sys_rst_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic run = 1'h0, dual = 1'h0, strobe = 1'h0, err, pready_o, pslverr_o, gate, marker, idclk, pair_valid_o, lock_o;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000, prdata_o, rd;
    logic [15:0] pa, pb, chan_a_o, chan_b_o;
    logic [3:0] stage_clk_en_o;
    int n_mismatch = 0, checks = 0, cycles = 0;
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
    dibd_host_model dibd_host_model_i (.mclk_i, .run_i(run), .dual_i(dual), .primary_o(pa), .secondary_o(pb),
        .gate_o(gate), .marker_o(marker), .idclk_o(idclk));
    dibd_top dibd_top_i (.mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .primary_input_bus_i(pa), .secondary_input_bus_i(pb), .transmit_gate_i(gate),
        .channel_marker_i(marker), .input_data_clock_i(idclk), .phase_strobe_i(strobe), .pll_lock_i(1'h1),
        .chan_a_o, .chan_b_o, .pair_valid_o, .stage_clk_en_o, .lock_or_divided_clock_o(lock_o));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'h1, wr, a, d};
        @(posedge mclk_i);
        penable_i <= 1'h1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'h1 && n < 20);
        if (pready_o !== 1'h1) n_mismatch++;
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask : apb
    task automatic t_regs;
        apb(1'h0, 12'h000, 32'h00000000);
        check("ctrl reset", rd, 32'h00000000);
        apb(1'h1, 12'h000, 32'h00000031);
        apb(1'h0, 12'h000, 32'h00000000);
        check("ctrl readback", rd, 32'h00000031);
        apb(1'h0, 12'hFFC, 32'h00000000);
        check("unmapped error", 32'(err), 32'h00000001);
    endtask : t_regs
    // Counts pulses over 16 settled cycles of one burst
    task automatic burst(input logic [31:0] ctrl, input int npv, input int ns1, input logic [7:0] bhi);
        int pv, s0, s1;
        {pv, s0, s1} = 96'h0;
        apb(1'h1, 12'h000, ctrl);
        @(posedge mclk_i);
        dual <= ctrl[2];
        run <= 1'h1;
        repeat (4) @(posedge mclk_i);
        repeat (16) begin
            @(posedge mclk_i);
            #1;
            pv += pair_valid_o;
            s0 += stage_clk_en_o[0];
            s1 += stage_clk_en_o[1];
        end
        check("pairs", 32'(pv), 32'(npv));
        check("stage 0", 32'(s0), 32'h00000008);
        check("stage 1", 32'(s1), 32'(ns1));
        check("chan b source", 32'(chan_b_o[15:8]), 32'(bhi));
        check("chan a source", 32'(chan_a_o[15:8]), 32'h000000A5);
        check("lock", 32'(lock_o), 32'h00000001);
        @(posedge mclk_i);
        run <= 1'h0;
        repeat (4) @(posedge mclk_i);
    endtask : burst
    task automatic t_two; burst(32'h00000000, 8, 0, 8'h5A); endtask : t_two
    task automatic t_four; burst(32'h00000010, 4, 4, 8'h5A); endtask : t_four
    task automatic t_gate; burst(32'h00000001, 8, 0, 8'hA5); endtask : t_gate
    task automatic t_mark; burst(32'h00000003, 8, 0, 8'hA5); endtask : t_mark
    task automatic t_dual; burst(32'h00000004, 4, 0, 8'h5A); endtask : t_dual
    // External 16x mode with strobe sync: restart gives a fixed divided-clock phase
    task automatic t_ext;
        apb(1'h1, 12'h000, 32'h00000078);
        @(posedge mclk_i);
        strobe <= 1'h1;
        @(posedge mclk_i);
        @(posedge mclk_i);
        #1;
        check("restart stages", 32'(stage_clk_en_o), 32'h0000000F);
        check("divided clock high", 32'(lock_o), 32'h00000001);
        repeat (8) @(posedge mclk_i);
        #1;
        check("divided clock low", 32'(lock_o), 32'h00000000);
        @(posedge mclk_i);
        strobe <= 1'h0;
    endtask : t_ext
    task automatic end_sim;
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        repeat (8) @(posedge mclk_i);
        sys_rst_i <= 1'h0;
        t_regs();
        t_two();
        t_four();
        t_gate();
        t_mark();
        t_dual();
        t_ext();
        end_sim();
    end
endmodule : dac_input_bus_demux_test
